// file: common/bfc_pkg.sv
// package: constants and types for the flash bus controller
`default_nettype none
package bfc_pkg;
  // array geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int BLK_W  = 4;
  // recovery after powerdown release, in ns
  localparam int CLK_NS      = 5;
  localparam int RD_WAKE_NS  = 400;
  localparam int WR_WAKE_NS  = 1000;
  localparam int RD_WAKE_CYC = (RD_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_WAKE_CYC = (WR_WAKE_NS + CLK_NS - 1) / CLK_NS;
  // bus cycle phase length in clocks
  localparam int PHASE_CYC   = 20;
  // command bytes written in the two-write sequences, suspend, resume and read modes
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONF  = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
  localparam logic [7:0] CMD_RESUME      = 8'hD0;
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  // user operations
  typedef enum logic [2:0] {
    BFC_OP_READ    = 3'h0,
    BFC_OP_WRITE   = 3'h1,
    BFC_OP_ERASE   = 3'h2,
    BFC_OP_SUSPEND = 3'h3,
    BFC_OP_RESUME  = 3'h4,
    BFC_OP_STATUS  = 3'h5,
    BFC_OP_ARRAY   = 3'h6
  } bfc_op_t;
endpackage
`default_nettype wire

// file: rtl/bfc_cycle.sv
// one strobed bus cycle on the flash pins: setup, strobe, release
`timescale 1ns/1ps
`default_nettype none
module bfc_cycle
  import bfc_pkg::*;
#(
  parameter int PHASE = PHASE_CYC
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // request
  input  wire logic              start,
  input  wire logic              is_write,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic                   done,
  output logic [DATA_W-1:0]      rdata,
  // flash pins
  output logic                   ce_n,
  output logic                   oe_n,
  output logic                   we_n,
  output logic [ADDR_W-1:0]      address_lines,
  output logic [DATA_W-1:0]      data_lines_o,
  output logic                   data_lines_oe,
  input  wire logic [DATA_W-1:0] data_lines_i
);
  initial begin
    if (PHASE < 2 || PHASE > 255) $error("bfc_cycle: PHASE out of range");
  end

  typedef enum logic [1:0] {
    CY_IDLE   = 2'b00,
    CY_SETUP  = 2'b01,
    CY_STROBE = 2'b11,
    CY_HOLD   = 2'b10
  } bfc_cy_t;

  bfc_cy_t           st_q, st_d;
  logic [7:0]        cnt_q, cnt_d;
  logic              wr_q, wr_d;
  logic [ADDR_W-1:0] a_q, a_d;
  logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
  logic              last;

  assign last = (cnt_q == 8'(PHASE - 1));

  // next state: address and data stay put through the strobe's rising edge
  always_comb begin
    st_d = st_q;
    cnt_d = last ? 8'h00 : cnt_q + 8'h01;
    wr_d = wr_q;
    a_d = a_q;
    wd_d = wd_q;
    rd_d = rd_q;
    done = 1'b0;
    case (st_q)
      CY_IDLE: begin
        cnt_d = 8'h00;
        if (start) begin
          st_d = CY_SETUP;
          wr_d = is_write;
          a_d = addr;
          wd_d = wdata;
        end
      end
      CY_SETUP:  if (last) st_d = CY_STROBE;
      CY_STROBE: begin
        if (last) begin
          st_d = CY_HOLD;
          if (!wr_q) rd_d = data_lines_i; // sample before oe rises
        end
      end
      CY_HOLD: begin
        if (last) begin
          st_d = CY_IDLE;
          done = 1'b1;
        end
      end
      default: st_d = CY_IDLE;
    endcase
  end

  // registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= CY_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      a_q <= '0;
      wd_q <= '0;
      rd_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      a_q <= a_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
    end
  end

  // pin drive: data driven only for writes, oe only for reads
  assign ce_n = (st_q == CY_IDLE);
  assign we_n = !(wr_q && st_q == CY_STROBE);
  assign oe_n = !(!wr_q && st_q == CY_STROBE);
  assign data_lines_oe = wr_q && (st_q != CY_IDLE);
  assign data_lines_o = wd_q;
  assign address_lines = a_q;
  assign rdata = rd_q;
endmodule
`default_nettype wire

// file: rtl/bfc_host.sv
// host controller driving a byte-wide block-erasable flash over its pins
`timescale 1ns/1ps
`default_nettype none
module bfc_host
  import bfc_pkg::*;
#(
  parameter int RD_WAKE = RD_WAKE_CYC,
  parameter int WR_WAKE = WR_WAKE_CYC,
  parameter int PHASE   = PHASE_CYC
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // user command port
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [2:0]        req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_data,
  input  wire logic              pd_request,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   busy,
  // flash pins
  output logic                   ce_n,
  output logic                   oe_n,
  output logic                   we_n,
  output logic                   powerdown_reset_n,
  output logic [ADDR_W-1:0]      address_lines,
  output logic [DATA_W-1:0]      data_lines_o,
  output logic                   data_lines_oe,
  input  wire logic [DATA_W-1:0] data_lines_i,
  input  wire logic              automation_idle
);
  initial begin
    if (RD_WAKE < 1 || WR_WAKE < RD_WAKE || WR_WAKE > 65535)
      $error("bfc_host: wake counts out of range");
  end

  typedef enum logic [2:0] {
    HS_DOWN  = 3'b000,
    HS_WAKE  = 3'b001,
    HS_IDLE  = 3'b011,
    HS_CYC1  = 3'b010,
    HS_CYC2  = 3'b110,
    HS_WAITR = 3'b111,
    HS_DONE  = 3'b101
  } bfc_hs_t;

  bfc_hs_t           st_q, st_d;
  logic [15:0]       wake_q, wake_d;
  logic [2:0]        op_q, op_d;
  logic [ADDR_W-1:0] a_q, a_d;
  logic [DATA_W-1:0] d_q, d_d, rsp_q, rsp_d;
  logic              rv_q, rv_d;
  logic              cy_start, cy_wr, cy_done;
  logic [ADDR_W-1:0] cy_addr;
  logic [DATA_W-1:0] cy_wdata, cy_rdata;
  logic              two_write, is_ctl_op, rd_ok, wr_ok, auto_ok;

  // erase and byte write need two writes, the rest one
  assign two_write = (op_q == BFC_OP_WRITE) || (op_q == BFC_OP_ERASE);
  assign rd_ok = (wake_q >= 16'(RD_WAKE));
  assign wr_ok = (wake_q >= 16'(WR_WAKE));
  // new write or erase only once the automaton is idle
  assign auto_ok = automation_idle;
  // only suspend and status may be sent to a busy automaton
  assign is_ctl_op = (req_op == BFC_OP_SUSPEND) || (req_op == BFC_OP_STATUS);

  // sequencing of the command port onto bus cycles
  always_comb begin
    st_d = st_q;
    wake_d = wake_q;
    op_d = op_q;
    a_d = a_q;
    d_d = d_q;
    rsp_d = rsp_q;
    rv_d = 1'b0;
    cy_start = 1'b0;
    cy_wr = 1'b0;
    cy_addr = a_q;
    cy_wdata = d_q;
    req_ready = 1'b0;
    case (st_q)
      HS_DOWN: begin
        wake_d = 16'h0000;
        if (!pd_request) st_d = HS_WAKE;
      end
      HS_WAKE: begin
        if (wake_q != 16'hFFFF) wake_d = wake_q + 16'h0001;
        if (pd_request) st_d = HS_DOWN;
        else if (wr_ok) st_d = HS_IDLE;
      end
      HS_IDLE: begin
        // a read while busy would meet status data, so reads wait for idle too
        req_ready = !pd_request && rd_ok && wr_ok && (auto_ok || is_ctl_op);
        if (pd_request) begin
          st_d = HS_DOWN;
        end else if (req_valid && req_ready) begin
          op_d = req_op;
          a_d = req_addr;
          d_d = req_data;
          st_d = HS_CYC1;
        end
      end
      HS_CYC1: begin
        // first cycle: setup command for two-write ops, else the single cycle
        cy_start = 1'b1;
        cy_wr = (op_q != BFC_OP_READ);
        case (op_q)
          BFC_OP_WRITE:   cy_wdata = CMD_WRITE_SETUP;
          BFC_OP_ERASE:   cy_wdata = CMD_ERASE_SETUP;
          BFC_OP_SUSPEND: cy_wdata = CMD_SUSPEND;
          BFC_OP_RESUME:  cy_wdata = CMD_RESUME;
          BFC_OP_STATUS:  cy_wdata = CMD_READ_STATUS;
          BFC_OP_ARRAY:   cy_wdata = CMD_READ_ARRAY;
          default:        cy_wdata = d_q;
        endcase
        st_d = HS_WAITR;
        if (two_write) st_d = HS_CYC2;
      end
      HS_CYC2: begin
        // engine takes a start only when idle: wait till it deselects
        if (ce_n) begin
          cy_start = 1'b1;
          cy_wr = 1'b1;
          cy_wdata = (op_q == BFC_OP_ERASE) ? CMD_ERASE_CONF : d_q;
          st_d = HS_WAITR;
        end
      end
      HS_WAITR: begin
        if (cy_done) begin
          rsp_d = cy_rdata;
          st_d = HS_DONE;
        end
      end
      HS_DONE: begin
        rv_d = 1'b1;
        st_d = HS_IDLE;
      end
      default: st_d = HS_DOWN;
    endcase
  end

  // registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= HS_DOWN;
      wake_q <= 16'h0000;
      op_q <= BFC_OP_READ;
      a_q <= '0;
      d_q <= '0;
      rsp_q <= '0;
      rv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      wake_q <= wake_d;
      op_q <= op_d;
      a_q <= a_d;
      d_q <= d_d;
      rsp_q <= rsp_d;
      rv_q <= rv_d;
    end
  end

  // powerdown pin from a flop; low while held in down state
  logic pd_n_q;
  always_ff @(posedge clock) begin
    if (sys_rst) pd_n_q <= 1'b0;
    else pd_n_q <= (st_d != HS_DOWN);
  end
  assign powerdown_reset_n = pd_n_q;

  assign rsp_valid = rv_q;
  assign rsp_data = rsp_q;
  // busy reflects our own sequencing and the device's automaton
  assign busy = (st_q != HS_IDLE) || !automation_idle;

  // one bus cycle engine, pins deselected between cycles
  bfc_cycle #(
    .PHASE(PHASE)
  ) u_cycle (
    .clock         (clock),
    .sys_rst       (sys_rst),
    .start         (cy_start),
    .is_write      (cy_wr),
    .addr          (cy_addr),
    .wdata         (cy_wdata),
    .done          (cy_done),
    .rdata         (cy_rdata),
    .ce_n          (ce_n),
    .oe_n          (oe_n),
    .we_n          (we_n),
    .address_lines (address_lines),
    .data_lines_o  (data_lines_o),
    .data_lines_oe (data_lines_oe),
    .data_lines_i  (data_lines_i)
  );
endmodule
`default_nettype wire

// file: tb/bfc_flash_model.sv
// behavioural model of the byte-wide block-erasable flash device
`timescale 1ns/1ps
`default_nettype none
module bfc_flash_model
  import bfc_pkg::*;
#(
  parameter int WR_CYC = 20,
  parameter int ER_CYC = 100
) (
  // pins from the host
  input wire logic        clock,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        pd_n,
  input wire logic [19:0] address_lines,
  input wire logic [7:0]  din,
  // device outputs
  output logic [7:0]      dout,
  output logic            dout_oe,
  output logic            automation_idle
);
  logic [7:0] mem [2**20];
  logic [7:0] cmd = 8'h00;
  logic       stat_md = 1'b0;
  logic       susp = 1'b0;
  int         cnt = 0;
  realtime    t_up = 0.0;
  initial foreach (mem[i]) mem[i] = 8'hff;
  always @(posedge pd_n) t_up = $realtime;
  // automaton timing; powerdown resets it and returns to array reads
  always @(posedge clock) begin
    if (!pd_n) begin
      cnt = 0;
      susp = 1'b0;
      stat_md = 1'b0;
      cmd = 8'h00;
    end else if (cnt > 0 && !susp) cnt = cnt - 1;
  end
  // latch at the strobe's rising edge; early writes after wake are lost
  always @(posedge we_n) begin
    if (pd_n && !ce_n && $realtime - t_up >= 1000.0) begin
      if (cmd == CMD_WRITE_SETUP) begin
        mem[address_lines] = din;
        cnt = WR_CYC;
        cmd = 8'h00;
      end else if (cmd == CMD_ERASE_SETUP && din == CMD_ERASE_CONF) begin
        for (int i = 0; i < 65536; i++) mem[{address_lines[19:16], i[15:0]}] = 8'hff;
        cnt = ER_CYC;
        cmd = 8'h00;
      end else begin
        susp = din == CMD_SUSPEND ? 1'b1 : (din == CMD_RESUME ? 1'b0 : susp);
        stat_md = din == CMD_READ_STATUS ? 1'b1 : (din == CMD_READ_ARRAY ? 1'b0 : stat_md);
        cmd = din;
      end
    end
  end
  // always driven, low only while work runs unsuspended
  assign automation_idle = !(cnt > 0 && !susp);
  // read drive needs select, output enable and wake
  assign dout_oe = !ce_n && !oe_n && we_n && pd_n;
  assign dout = stat_md ? {automation_idle, 7'h00} : mem[address_lines];
endmodule
`default_nettype wire

// file: tb/bfc_host_asserts.sv
// checker for the flash host controller pins and user port
`timescale 1ns/1ps
`default_nettype none
module bfc_host_asserts
  import bfc_pkg::*;
#(
  parameter int RD_WAKE = RD_WAKE_CYC,
  parameter int WR_WAKE = WR_WAKE_CYC,
  parameter int PHASE   = PHASE_CYC
) (
  // clock and reset
  input wire logic              clock,
  input wire logic              sys_rst,
  // user side
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire logic [2:0]        req_op,
  input wire logic              pd_request,
  input wire logic              rsp_valid,
  input wire logic              busy,
  // flash pins
  input wire logic              ce_n,
  input wire logic              oe_n,
  input wire logic              we_n,
  input wire logic              powerdown_reset_n,
  input wire logic [ADDR_W-1:0] address_lines,
  input wire logic [DATA_W-1:0] data_lines_o,
  input wire logic              data_lines_oe,
  input wire logic              automation_idle
);
  localparam int RD_LAT = 3 * PHASE + 3;
  localparam int WR_LAT = 6 * PHASE + 4;
  int up_q;
  int up_d;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////
  // cycles awake, saturating so the counter never wraps
  always_comb begin
    up_d = !powerdown_reset_n ? 0 : (up_q < WR_WAKE ? up_q + 1 : up_q);
  end
  always_ff @(posedge clock) begin
    up_q <= up_d;
  end
  sequence s_take_rd;
    req_valid && req_ready && req_op == 3'h0;
  endsequence
  sequence s_take_wr;
    req_valid && req_ready && (req_op == 3'h1 || req_op == 3'h2);
  endsequence
  ////////////////////////////////////////////////////////////////////
  chk_read_lat: assert property (s_take_rd |-> ##RD_LAT rsp_valid)
    else $error("read answer off time");
  chk_pair_lat: assert property (s_take_wr |-> ##WR_LAT rsp_valid)
    else $error("two-write answer off time");
  chk_rst_hold: assert property ($fell(sys_rst) |-> !powerdown_reset_n)
    else $error("device woke during reset");
  chk_pd_enter: assert property (pd_request && !busy |-> ##[1:3] !powerdown_reset_n)
    else $error("powerdown not entered");
  chk_wake_wait: assert property (req_ready |-> up_q >= WR_WAKE - 1)
    else $error("command before wake time");
  chk_ce_gate: assert property (ce_n |-> oe_n && we_n)
    else $error("strobe while deselected");
  chk_read_drive: assert property (!oe_n |-> we_n && !data_lines_oe)
    else $error("host drives during read");
  chk_write_drive: assert property (!we_n |-> !ce_n && oe_n && data_lines_oe)
    else $error("write strobe without data");
  chk_write_hold: assert property ($rose(we_n) |->
    $stable(address_lines) && $stable(data_lines_o) && data_lines_oe)
    else $error("address or data moved at strobe edge");
  chk_idle_wait: assert property (req_ready && req_op != 3'h3 && req_op != 3'h5
    |-> automation_idle)
    else $error("request taken while automaton busy");
endmodule
bind bfc_host bfc_host_asserts #(.RD_WAKE(RD_WAKE), .WR_WAKE(WR_WAKE), .PHASE(PHASE)) chk_u (
  .clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
  .req_op(req_op), .pd_request(pd_request), .rsp_valid(rsp_valid), .busy(busy),
  .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .powerdown_reset_n(powerdown_reset_n),
  .address_lines(address_lines), .data_lines_o(data_lines_o),
  .data_lines_oe(data_lines_oe), .automation_idle(automation_idle));
`default_nettype wire

// file: tb/bfc_host_test.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module bfc_host_test;
  import bfc_pkg::*;
  logic clock = 0, sys_rst = 1, req_valid = 0, pd_request = 0;
  logic [2:0] req_op = 0;
  logic [19:0] req_addr = 0, address_lines;
  logic [7:0] req_data = 0, pat = 0, rsp_data, data_lines_o, data_lines_i, dout;
  logic req_ready, rsp_valid, busy, ce_n, oe_n, we_n, pd_n, data_lines_oe, dout_oe, idle;
  int bad_count = 0, n_checks = 0;
  logic [8:0] exp_q [$];
  logic [8:0] e;
  logic [19:0] a [4];
  logic [7:0] d [4];
  always #2.5 clock = ~clock;
  // floating bus shows a changing pattern, not the last value
  always @(posedge clock) pat <= pat + 8'h01;
  assign data_lines_i = dout_oe ? dout : (data_lines_oe ? data_lines_o : pat);
  bfc_host #(.PHASE(2)) dut_u (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .pd_request(pd_request), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .powerdown_reset_n(pd_n),
    .address_lines(address_lines), .data_lines_o(data_lines_o),
    .data_lines_oe(data_lines_oe), .data_lines_i(data_lines_i), .automation_idle(idle));
  bfc_flash_model dev_u (.clock(clock), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .pd_n(pd_n),
    .address_lines(address_lines), .din(data_lines_i), .dout(dout), .dout_oe(dout_oe),
    .automation_idle(idle));
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one user request; the answer is noted for the monitor
  task automatic op(input logic [2:0] o, input logic [19:0] ad, input logic [7:0] dt,
                    input logic care, input logic [7:0] want);
    int n;
    @(negedge clock);
    req_op = o;
    req_addr = ad;
    req_data = dt;
    req_valid = 1'b1;
    exp_q.push_back({care, want});
    n = 0;
    #1;
    while (req_ready !== 1'b1 && n < 3000) begin
      @(negedge clock);
      #1;
      n++;
    end
    if (n >= 3000) bad_count++;
    @(negedge clock);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    if (n >= 300) bad_count++;
  endtask
  ////////////////////////////////////////////////////////////////////
  // monitor: oldest note against each answer
  always @(negedge clock) begin
    if (rsp_valid === 1'b1) begin
      e = exp_q.pop_front();
      if (e[8]) chk(rsp_data, e[7:0]);
    end
  end
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h6c5b_051d));
    repeat (10) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      a[i] = {i[3:0], 16'($urandom)};
      d[i] = 8'($urandom);
      op(3'h1, a[i], d[i], 1'b0, 8'h00);
    end
    chk({7'h00, busy}, 8'h01);
    for (int i = 0; i < 4; i++) op(3'h0, a[i], 8'h00, 1'b1, d[i]);
    op(3'h2, a[1], 8'h00, 1'b0, 8'h00);
    op(3'h3, a[1], 8'h00, 1'b0, 8'h00);
    op(3'h0, a[2], 8'h00, 1'b1, d[2]);
    op(3'h4, a[1], 8'h00, 1'b0, 8'h00);
    op(3'h0, a[1], 8'h00, 1'b1, 8'hff);
    op(3'h0, a[0], 8'h00, 1'b1, d[0]);
    op(3'h5, a[0], 8'h00, 1'b0, 8'h00);
    op(3'h0, a[0], 8'h00, 1'b1, 8'h80);
    @(negedge clock);
    pd_request = 1'b1;
    repeat (4) @(negedge clock);
    chk({7'h00, pd_n}, 8'h00);
    chk({7'h00, req_ready}, 8'h00);
    pd_request = 1'b0;
    op(3'h0, a[3], 8'h00, 1'b1, d[3]);
    op(3'h6, a[3], 8'h00, 1'b0, 8'h00);
    @(negedge clock);
    chk(8'(exp_q.size()), 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
